// file: rtl/logic_supply_select_control.sv
// Logic-supply select control with battery-check register and AXI4-Lite slave
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "supply_select_defines.svh"

module logic_supply_select_control #(
   parameter int unsigned XtalHz = `XTAL_HZ_DEFAULT,
   parameter int unsigned WindowTicks = `HOLD_WINDOW_MS * XtalHz / `MS_PER_SECOND
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic coreClockSelect,
   input wire logic xtalStarted,
   input wire logic xtalTick,
   input wire logic comparatorRaw,
   output logic railBypassSwitch,
   output logic comparatorEnable,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Address decode: byte address to register index
   function automatic logic [7:0] regIndex(input logic [31:0] addr);
      return addr[`INDEX_SHIFT +: 8];
   endfunction

   function automatic logic isMapped(input logic [31:0] addr);
      logic [7:0] idx;
      idx = regIndex(addr);
      return (addr[31:`INDEX_SHIFT + 8] == '0) && (addr[1:0] == 2'b00) &&
             (idx == `BACKUP_CTRL_INDEX || idx == `EVENT_STATUS_INDEX ||
              idx == `EVENT_MASK_INDEX || idx == `RAIL_STATE_INDEX);
   endfunction

   supply_select_pkg::backup_ctrl_t ctrlQ;
   supply_select_pkg::event_t statusQ;
   supply_select_pkg::event_t maskQ;
   supply_select_pkg::event_t eventNow;
   logic cmpSync1Q;
   logic cmpSync2Q;
   logic windowActiveQ;
   logic [`WINDOW_COUNT_WIDTH-1:0] windowCountQ;
   logic railFullD;
   logic railFullQ;
   logic awHeldQ;
   logic wHeldQ;
   logic [31:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic awTake;
   logic wTake;
   logic doWrite;
   logic [31:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic awHeldD;
   logic wHeldD;
   logic bvalidD;
   logic arTake;
   logic rvalidD;
   logic statusReadClear;
   logic [31:0] readWord;

   localparam logic [`WINDOW_COUNT_WIDTH-1:0] WindowLast =
      `WINDOW_COUNT_WIDTH'(WindowTicks - 1);

   // Two-stage synchroniser; a halted comparator is flushed so enabling raises no false low event
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmpSync1Q <= 1'b0;
         cmpSync2Q <= 1'b0;
      end else begin
         cmpSync1Q <= comparatorRaw && ctrlQ.cmpEnable;
         cmpSync2Q <= cmpSync1Q && ctrlQ.cmpEnable;
      end
   end

   // Post-reset full-supply window, counted in crystal ticks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         windowActiveQ <= 1'b1;
         windowCountQ <= '0;
      end else if (windowActiveQ && xtalStarted && xtalTick) begin
         if (windowCountQ == WindowLast) begin
            windowActiveQ <= 1'b0;
         end
         windowCountQ <= windowCountQ + 1'b1;
      end
   end

   // Rail selection: any forcing source gives the full supply
   assign railFullD = coreClockSelect || ctrlQ.boost || windowActiveQ;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         railFullQ <= `RAIL_FULL_RESET;
      end else begin
         railFullQ <= railFullD;
      end
   end

   assign railBypassSwitch = railFullQ;

   // Write channel handshake
   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign wrAddr = awHeldQ ? awAddrQ : s_axi_awaddr;
   assign wrData = wHeldQ ? wDataQ : s_axi_wdata;
   assign wrStrb = wHeldQ ? wStrbQ : s_axi_wstrb;
   assign doWrite = (awHeldQ || awTake) && (wHeldQ || wTake) && !s_axi_bvalid;
   assign awHeldD = (awHeldQ || awTake) && !doWrite;
   assign wHeldD = (wHeldQ || wTake) && !doWrite;
   assign bvalidD = doWrite || (s_axi_bvalid && !s_axi_bready);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         awHeldQ <= awHeldD;
         wHeldQ <= wHeldD;
         if (awTake) begin
            awAddrQ <= s_axi_awaddr;
         end
         if (wTake) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
         s_axi_awready <= !awHeldD && !bvalidD;
         s_axi_wready <= !wHeldD && !bvalidD;
         s_axi_bvalid <= bvalidD;
         if (doWrite) begin
            s_axi_bresp <= isMapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Backup control: boost and enable writable, low flag from comparator
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrlQ.boost <= `BOOST_RESET;
         ctrlQ.cmpEnable <= `CMP_EN_RESET;
         ctrlQ.cmpLow <= `CMP_LOW_RESET;
         ctrlQ.reservedOne <= `RESERVED_READ;
      end else begin
         if (doWrite && wrStrb[0] && isMapped(wrAddr) && regIndex(wrAddr) == `BACKUP_CTRL_INDEX) begin
            ctrlQ.boost <= wrData[`BOOST_BIT];
            ctrlQ.cmpEnable <= wrData[`CMP_EN_BIT];
         end
         ctrlQ.cmpLow <= cmpSync2Q && ctrlQ.cmpEnable;
         ctrlQ.reservedOne <= `RESERVED_READ;
      end
   end

   assign comparatorEnable = ctrlQ.cmpEnable;

   // Mask register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         maskQ <= '0;
      end else if (doWrite && wrStrb[0] && isMapped(wrAddr) && regIndex(wrAddr) == `EVENT_MASK_INDEX) begin
         maskQ <= wrData[$bits(supply_select_pkg::event_t)-1:0];
      end
   end

   // Event detection
   always_comb begin
      eventNow.cmpLowRise = cmpSync2Q && ctrlQ.cmpEnable && !ctrlQ.cmpLow;
      eventNow.windowEnd = windowActiveQ && xtalStarted && xtalTick && (windowCountQ == WindowLast);
      eventNow.railChange = railFullD != railFullQ;
   end

   // Sticky status; a new event wins over the read clear
   assign statusReadClear = arTake && isMapped(s_axi_araddr) && regIndex(s_axi_araddr) == `EVENT_STATUS_INDEX;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         statusQ <= '0;
      end else begin
         statusQ <= (statusReadClear ? '0 : statusQ) | eventNow;
      end
   end

   // Level interrupt from unmasked sticky bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((statusReadClear ? '0 : statusQ) | eventNow) & maskQ);
      end
   end

   // Read data selection
   always_comb begin
      readWord = '0;
      unique case (regIndex(s_axi_araddr))
         `BACKUP_CTRL_INDEX: readWord[3:0] = ctrlQ;
         `EVENT_STATUS_INDEX: readWord[2:0] = statusQ;
         `EVENT_MASK_INDEX: readWord[2:0] = maskQ;
         `RAIL_STATE_INDEX: readWord[2:0] = {coreClockSelect, windowActiveQ, railFullQ};
         default: readWord = '0;
      endcase
      if (!isMapped(s_axi_araddr)) begin
         readWord = '0;
      end
   end

   // Read channel handshake, answer one cycle after the address
   assign arTake = s_axi_arvalid && s_axi_arready;
   assign rvalidD = arTake || (s_axi_rvalid && !s_axi_rready);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalidD;
         s_axi_rvalid <= rvalidD;
         if (arTake) begin
            s_axi_rdata <= readWord;
            s_axi_rresp <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Checks
   sequence s_clockRc;
      coreClockSelect;
   endsequence

   property p_rcForcesFull;
      @(posedge clk) disable iff (reset) s_clockRc |=> railBypassSwitch;
   endproperty
   a_rcForcesFull: assert property (p_rcForcesFull) else $error("RC clock did not force full rail");

   property p_resetFull;
      @(posedge clk) $fell(reset) |-> railBypassSwitch;
   endproperty
   a_resetFull: assert property (p_resetFull) else $error("Rail not full at reset release");

   sequence s_lowSelect;
      !coreClockSelect && !ctrlQ.boost && !windowActiveQ;
   endsequence

   property p_boostSelect;
      @(posedge clk) disable iff (reset)
         (s_lowSelect |=> !railBypassSwitch) and
         ((!coreClockSelect && ctrlQ.boost) |=> railBypassSwitch);
   endproperty
   a_boostSelect: assert property (p_boostSelect) else $error("Rail level does not follow boost flag");

   property p_boostReset;
      @(posedge clk) $fell(reset) |-> !ctrlQ.boost && !ctrlQ.cmpEnable;
   endproperty
   a_boostReset: assert property (p_boostReset) else $error("Control bits not cleared by reset");

   property p_windowHolds;
      @(posedge clk) disable iff (reset) windowActiveQ |=> railBypassSwitch;
   endproperty
   a_windowHolds: assert property (p_windowHolds) else $error("Rail dropped inside post-reset window");

   property p_windowEnds;
      @(posedge clk) disable iff (reset)
         (windowActiveQ && xtalStarted && xtalTick && windowCountQ == WindowLast) |=> !windowActiveQ;
   endproperty
   a_windowEnds: assert property (p_windowEnds) else $error("Window did not end at terminal count");

   sequence s_ctrlRead;
      arTake && isMapped(s_axi_araddr) && regIndex(s_axi_araddr) == `BACKUP_CTRL_INDEX;
   endsequence

   property p_reservedReadsOne;
      @(posedge clk) disable iff (reset) s_ctrlRead |=> s_axi_rvalid && s_axi_rdata[`RESERVED_BIT];
   endproperty
   a_reservedReadsOne: assert property (p_reservedReadsOne) else $error("Reserved bit did not read 1");

   property p_lowFlag;
      @(posedge clk) disable iff (reset) ctrlQ.cmpEnable ##1 ctrlQ.cmpEnable |-> ctrlQ.cmpLow == $past(cmpSync2Q);
   endproperty
   a_lowFlag: assert property (p_lowFlag) else $error("Low flag does not follow comparator");

   property p_enableWrite;
      @(posedge clk) disable iff (reset)
         (doWrite && wrStrb[0] && isMapped(wrAddr) && regIndex(wrAddr) == `BACKUP_CTRL_INDEX)
         |=> ctrlQ.cmpEnable == $past(wrData[`CMP_EN_BIT]) && comparatorEnable == ctrlQ.cmpEnable;
   endproperty
   a_enableWrite: assert property (p_enableWrite) else $error("Enable bit not written");

   property p_registerMap;
      @(posedge clk) disable iff (reset) s_ctrlRead |=> s_axi_rdata[31:4] == '0 && s_axi_rresp == `RESP_OKAY;
   endproperty
   a_registerMap: assert property (p_registerMap) else $error("Control register read malformed");

   // Status, interrupt and bus error checks
   property p_eventSticky;
      @(posedge clk) disable iff (reset) (eventNow != '0) |=> (statusQ & $past(eventNow)) == $past(eventNow);
   endproperty
   a_eventSticky: assert property (p_eventSticky) else $error("Event did not set its status bit");

   property p_statusReadClear;
      @(posedge clk) disable iff (reset) (statusReadClear && eventNow == '0) |=> statusQ == '0;
   endproperty
   a_statusReadClear: assert property (p_statusReadClear) else $error("Status not cleared by read");

   property p_irqLevel;
      @(posedge clk) disable iff (reset) 1'b1 |=> irq == |(statusQ & $past(maskQ));
   endproperty
   a_irqLevel: assert property (p_irqLevel) else $error("Interrupt does not follow unmasked status");

   property p_writeError;
      @(posedge clk) disable iff (reset) (doWrite && !isMapped(wrAddr)) |=> s_axi_bvalid && s_axi_bresp == `RESP_SLVERR;
   endproperty
   a_writeError: assert property (p_writeError) else $error("Unmapped write not answered with error");

   property p_readError;
      @(posedge clk) disable iff (reset)
         (arTake && !isMapped(s_axi_araddr)) |=> s_axi_rdata == '0 && s_axi_rresp == `RESP_SLVERR;
   endproperty
   a_readError: assert property (p_readError) else $error("Unmapped read not answered with error");

endmodule

// file: rtl/supply_select_defines.svh
// Constants for the logic-supply select control block
//
// Contract
// - RC oscillator clock forces rail to full
// - Reset forces rail bypass switch on
// - Crystal clock: boost flag picks full/regulated
// - Boost flag clears to 0 at reset
// - Full rail held 0.5 s after crystal start
// - 4-bit control register: boost, enable, low
// - Reserved bit 3 reads 1, writes ignored
// - Low flag 1 below reference, initially 0
// - Comparator enable resets 0, write 1 enables
`ifndef SUPPLY_SELECT_DEFINES_SVH
`define SUPPLY_SELECT_DEFINES_SVH

// Register indices; byte address is four times the index
`define BACKUP_CTRL_INDEX 8'h37
`define EVENT_STATUS_INDEX 8'h38
`define EVENT_MASK_INDEX 8'h39
`define RAIL_STATE_INDEX 8'h3a
`define INDEX_SHIFT 2

// Backup control field positions
`define BOOST_BIT 0
`define CMP_EN_BIT 1
`define CMP_LOW_BIT 2
`define RESERVED_BIT 3

// Reset values
`define BOOST_RESET 1'b0
`define CMP_EN_RESET 1'b0
`define CMP_LOW_RESET 1'b0
`define RESERVED_READ 1'b1
`define RAIL_FULL_RESET 1'b1

// Timing
`define HOLD_WINDOW_MS 500
`define MS_PER_SECOND 1000
`define XTAL_HZ_DEFAULT 32768
`define WINDOW_COUNT_WIDTH 24

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: rtl/supply_select_pkg.sv
// Types for the logic-supply select control block
package supply_select_pkg;

   // Backup control register layout
   typedef struct packed {
      logic reservedOne;
      logic cmpLow;
      logic cmpEnable;
      logic boost;
   } backup_ctrl_t;

   // Sticky event layout, shared by status and mask
   typedef struct packed {
      logic railChange;
      logic windowEnd;
      logic cmpLowRise;
   } event_t;

   // Read-only rail state layout
   typedef struct packed {
      logic clockSelectRc;
      logic windowActive;
      logic railFull;
   } rail_state_t;

endpackage

// file: test/rail_regulator_model.sv
// Behavioural model of the rail regulator, bypass switch and battery comparator
`timescale 1ns/1ps
module rail_regulator_model (
   input wire logic clk,
   input wire logic railBypassSwitch,
   input wire logic comparatorEnable,
   input wire logic batteryLow,
   output logic railAtFull,
   output logic comparatorRaw
);
   logic idleToggle = 1'b0;
   // Closed switch ties the rail to full supply, open leaves the regulated level
   assign railAtFull = railBypassSwitch;
   // Halted comparator output wanders each cycle
   always @(posedge clk) idleToggle <= ~idleToggle;
   // Running comparator reports below reference as 1
   assign comparatorRaw = comparatorEnable ? batteryLow : idleToggle;
endmodule

// file: test/tb_logic_supply_select_control.sv
// Self-checking bench for the logic-supply select control block
`timescale 1ns/1ps
`include "supply_select_defines.svh"
module tb_logic_supply_select_control;
   localparam int WT = 8;
   localparam logic [31:0] CTRL = 32'(`BACKUP_CTRL_INDEX) << `INDEX_SHIFT;
   localparam logic [31:0] STAT = 32'(`EVENT_STATUS_INDEX) << `INDEX_SHIFT;
   localparam logic [31:0] MASK = 32'(`EVENT_MASK_INDEX) << `INDEX_SHIFT;
   localparam logic [31:0] RAIL = 32'(`RAIL_STATE_INDEX) << `INDEX_SHIFT;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic coreClockSelect = 1'b0;
   logic xtalStarted = 1'b0;
   logic xtalTick = 1'b0;
   logic batteryLow = 1'b0;
   logic comparatorRaw, railBypassSwitch, comparatorEnable, irq, railAtFull;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, data;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   int err_total = 0;
   int n_checks = 0;

   // Free-running system clock
   always #20 clk = ~clk;

   logic_supply_select_control #(.WindowTicks(WT)) i_dut (
      .clk(clk), .reset(reset), .coreClockSelect(coreClockSelect), .xtalStarted(xtalStarted),
      .xtalTick(xtalTick), .comparatorRaw(comparatorRaw), .railBypassSwitch(railBypassSwitch),
      .comparatorEnable(comparatorEnable), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   rail_regulator_model i_rail (
      .clk(clk), .railBypassSwitch(railBypassSwitch), .comparatorEnable(comparatorEnable),
      .batteryLow(batteryLow), .railAtFull(railAtFull), .comparatorRaw(comparatorRaw));

   // Comparisons, one per kind of result
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Register write; address and data offered together, each released when taken
   task automatic axi_write(input logic [31:0] addr, input logic [31:0] val, output logic [1:0] r);
      bit awDone, wDone;
      awDone = 0;
      wDone = 0;
      awaddr <= addr;
      wdata <= val;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge clk);
         if (!awDone && awready === 1'b1) begin
            awDone = 1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready === 1'b1) begin
            wDone = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   // Register read
   task automatic axi_read(input logic [31:0] addr, output logic [31:0] d, output logic [1:0] r);
      araddr <= addr;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Crystal period pulses
   task automatic tick(input int n);
      repeat (n) begin
         xtalTick <= 1'b1;
         @(posedge clk);
         xtalTick <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog at 10000 cycles, far beyond the under two hundred cycles the tests need
   initial begin
      #400000;
      err_total++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      chk_bit("rail in reset", 1'b1, railAtFull);
      reset <= 1'b0;
      @(posedge clk);
      axi_read(CTRL, data, resp);
      chk_word("ctrl after reset", 32'h8, data);
      chk_bit("enable after reset", 1'b0, comparatorEnable);
      // Window counts only once the crystal runs
      tick(WT);
      chk_bit("rail before start", 1'b1, railAtFull);
      xtalStarted <= 1'b1;
      tick(WT - 1);
      repeat (2) @(posedge clk);
      chk_bit("rail window open", 1'b1, railAtFull);
      tick(1);
      repeat (2) @(posedge clk);
      chk_bit("rail window closed", 1'b0, railAtFull);
      axi_read(STAT, data, resp);
      chk_word("status window", 32'h6, data);
      axi_read(STAT, data, resp);
      chk_word("status cleared", 32'h0, data);
      chk_bit("irq masked", 1'b0, irq);
      // Boost with rail-change interrupt unmasked
      axi_write(MASK, 32'h4, resp);
      axi_read(MASK, data, resp);
      chk_word("mask readback", 32'h4, data);
      axi_write(CTRL, 32'hf, resp);
      chk_resp("ctrl write", `RESP_OKAY, resp);
      repeat (2) @(posedge clk);
      chk_bit("rail boost", 1'b1, railAtFull);
      chk_bit("irq rail", 1'b1, irq);
      axi_read(CTRL, data, resp);
      chk_word("ctrl boost", 32'hb, data);
      axi_read(STAT, data, resp);
      chk_word("status rail", 32'h4, data);
      repeat (2) @(posedge clk);
      chk_bit("irq cleared", 1'b0, irq);
      // Comparator low, flag bit not writable
      batteryLow <= 1'b1;
      axi_write(CTRL, 32'h3, resp);
      repeat (5) @(posedge clk);
      axi_read(CTRL, data, resp);
      chk_word("ctrl low", 32'hf, data);
      axi_read(STAT, data, resp);
      chk_word("status low", 32'h1, data);
      chk_bit("enable out", 1'b1, comparatorEnable);
      chk_bit("irq cmp masked", 1'b0, irq);
      batteryLow <= 1'b0;
      repeat (5) @(posedge clk);
      axi_read(CTRL, data, resp);
      chk_word("ctrl high", 32'hb, data);
      batteryLow <= 1'b1;
      axi_write(CTRL, 32'h1, resp);
      repeat (5) @(posedge clk);
      axi_read(CTRL, data, resp);
      chk_word("ctrl disabled", 32'h9, data);
      // RC clock overrides a clear boost flag
      axi_write(CTRL, 32'h0, resp);
      coreClockSelect <= 1'b1;
      repeat (2) @(posedge clk);
      chk_bit("rail rc clock", 1'b1, railAtFull);
      axi_read(RAIL, data, resp);
      chk_word("rail state rc", 32'h5, data);
      coreClockSelect <= 1'b0;
      repeat (2) @(posedge clk);
      chk_bit("rail regulated", 1'b0, railAtFull);
      // Unmapped address
      axi_read(32'h100, data, resp);
      chk_resp("unmapped read", `RESP_SLVERR, resp);
      chk_word("unmapped data", 32'h0, data);
      axi_write(32'h100, 32'h1, resp);
      chk_resp("unmapped write", `RESP_SLVERR, resp);
      // Reset in mid-run clears boost and reopens the window
      axi_write(CTRL, 32'h1, resp);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      chk_bit("rail second reset", 1'b1, railAtFull);
      reset <= 1'b0;
      @(posedge clk);
      axi_read(CTRL, data, resp);
      chk_word("ctrl second reset", 32'h8, data);
      chk_bit("rail window again", 1'b1, railAtFull);
      finish_test();
   end
endmodule
